// *** rtl/sadc_pkg.sv ***
// constants, field layout and mode codes for the serial converter control block
// assumes a 125 MHz system clock and a slow serial master on the pins
// What this block does
// - track/hold acquires while the last three control bits shift in.
// - two low control bits pick full down, fast down, internal or external clock.
// - external mode: strobe high one serial clock period after last control bit.
// - external mode: twelve bit decisions appear on the next twelve falling edges.
// - external mode: strobe and data float on select high, strobe low after fall.
// - internal mode: strobe low during conversion, at most 7.5us when pin floats.
// - internal mode: result held, shifted MSB first after strobe rises.
// - internal mode: select high blocks input, floats data, keeps conversion, strobe driven.
// - select fall alone starts nothing; first high bit is start and MSB.
// - conversion begins on the falling edge after the eighth control bit.
// - start bit accepted when idle or after decision bit 3 was shifted out.
// - select toggled mid external conversion aborts it; next high bit starts anew.
// - back to back conversions at 15 or 16 clocks with select low.
// - power-up enters internal mode with strobe high; no starts for 10us.
// - after power-up data out gives zeros until a first conversion.
// - floating shutdown pin selects external compensation, driven high internal; here floating or high only picks the internal clock rate.
// - software power-down keeps interface alive; shutdown pin low stops everything.
// - with select low, data in is sampled on each serial clock rise.
// - results leave MSB first on serial clock falling edges.
// - power-down request finishes the conversion first; a start bit powers up.
// - internal conversion clock 1.8MHz with pin floating, 225kHz when high.
package sadc_pkg;
	localparam int CLK_MHZ          = 125;
	localparam int POR_US           = 10;
	localparam int POR_CYC          = POR_US * CLK_MHZ;
	localparam int INT_FAST_KHZ     = 1800;
	localparam int INT_SLOW_KHZ     = 225;
	localparam int INT_FAST_CYC     = (CLK_MHZ * 1000) / INT_FAST_KHZ;
	localparam int INT_SLOW_CYC     = (CLK_MHZ * 1000) / INT_SLOW_KHZ;
	localparam int PU_FAST_US       = 5;
	localparam int PU_BUF_OFF_US    = 2;
	localparam int PU_FULL_US       = 300;
	localparam int PU_FAST_CYC      = PU_FAST_US * CLK_MHZ;
	localparam int PU_BUF_OFF_CYC   = PU_BUF_OFF_US * CLK_MHZ;
	localparam int PU_FULL_CYC      = PU_FULL_US * CLK_MHZ;
	localparam int RES_BITS         = 10;
	localparam int CONV_STEPS       = 12;
	localparam int CTRL_BITS        = 8;
	localparam int START_OK_OUT     = 3;
	localparam int TRACK_FROM_BIT   = 5;
	localparam int OUT_SR_W         = 16;
	localparam int SYNC_W           = 5;
	localparam logic [1:0] PD_FULL  = 2'b00;
	localparam logic [1:0] PD_FAST  = 2'b01;
	localparam logic [1:0] PD_INT   = 2'b10;
	localparam logic [1:0] PD_EXT   = 2'b11;
	localparam int F_SEL_HI         = 6;
	localparam int F_SEL_LO         = 4;
	localparam int F_POL            = 3;
	localparam int F_CFG            = 2;
	localparam int F_PD_HI          = 1;
	localparam int F_PD_LO          = 0;
	typedef enum logic [1:0] {
		SADC_IDLE = 2'b00,
		SADC_EXT  = 2'b01,
		SADC_INT  = 2'b10
	} sadc_conv_t;
endpackage

// *** rtl/sadc_sar.sv ***
// successive-approximation register: one decision per step pulse
// assumes sample holds the digitised input at start
`timescale 1ns/1ns
module sadc_sar
	import sadc_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire logic                start,
	input  wire logic                step,
	input  wire logic [RES_BITS-1:0] sample,
	output logic                     bit_q,
	output logic                     done,
	output logic      [RES_BITS-1:0] result
);
	logic [RES_BITS-1:0] held_reg, held_next;
	logic [RES_BITS-1:0] res_reg, res_next;
	logic [3:0]          cnt_reg, cnt_next;
	logic                bit_reg, bit_next;
	logic [RES_BITS-1:0] trial;

	always_comb begin
		held_next = held_reg;
		res_next  = res_reg;
		cnt_next  = cnt_reg;
		bit_next  = bit_reg;
		trial     = '0;
		if (start) begin
			held_next = sample;
			res_next  = '0;
			cnt_next  = '0;
			bit_next  = 1'b0;
		end else if (step && cnt_reg < 4'(CONV_STEPS)) begin
			cnt_next = cnt_reg + 4'h1;
			if (cnt_reg < 4'(RES_BITS)) begin
				trial    = res_reg | (10'h200 >> cnt_reg);
				bit_next = (held_reg >= trial);
				if (held_reg >= trial)
					res_next = trial;
			end else begin
				bit_next = 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			held_reg <= '0;
			res_reg  <= '0;
			cnt_reg  <= 4'(CONV_STEPS);
			bit_reg  <= 1'b0;
		end else begin
			held_reg <= held_next;
			res_reg  <= res_next;
			cnt_reg  <= cnt_next;
			bit_reg  <= bit_next;
		end
	end

	assign bit_q  = bit_reg;
	assign done   = (cnt_reg == 4'(CONV_STEPS));
	assign result = res_reg;
endmodule

// *** rtl/sadc_sync.sv ***
// two-flop synchroniser for pin inputs
// assumes inputs are asynchronous to clk
`timescale 1ns/1ns
module sadc_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] meta_next;
	logic [W-1:0] q_reg;
	logic [W-1:0] q_next;

	always_comb begin
		meta_next = d;
		q_next    = meta_reg;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_reg <= '0;
			q_reg    <= '0;
		end else begin
			meta_reg <= meta_next;
			q_reg    <= q_next;
		end
	end

	assign q = q_reg;
endmodule

// *** rtl/sadc_top.sv ***
// serial interface, clock modes and power control of the converter
// assumes pins are asynchronous; ANALOG_CODE is the digitised selected input
`timescale 1ns/1ns
module sadc_top
	import sadc_pkg::*;
#(
	parameter int PU_FULL_CYCLES = PU_FULL_CYC
) (
	input  wire logic                CLK,
	input  wire logic                RST_N,
	input  wire logic                CS_N,
	input  wire logic                SCLK,
	input  wire logic                DIN,
	input  wire logic                SHUTDOWN_N_PIN,
	input  wire logic                SHUTDOWN_PIN_OPEN,
	input  wire logic                REF_BUFFER_EN,
	input  wire logic [RES_BITS-1:0] ANALOG_CODE,
	output logic                     DOUT,
	output logic                     DOUT_OE,
	output logic                     CONVERSION_STROBE,
	output logic                     CONVERSION_STROBE_OE,
	output logic                     TRACK,
	output logic [2:0]               CHANNEL_SELECT,
	output logic                     POLARITY_SELECT,
	output logic                     INPUT_CONFIG_SELECT,
	output logic                     EXT_CLOCK_MODE,
	output logic                     POWERED_UP,
	output logic                     CONVERTING
);
	import sadc_pkg::*;

	logic [SYNC_W-1:0] sync_q;
	logic sclk_s, cs_n_s, din_s, shutdown_n_pin_n_s, shutdown_n_pin_open_s;
	logic sclk_d_reg, sclk_d_next, cs_d_reg, cs_d_next;
	logic sclk_rise, sclk_fall, cs_rise;
	logic [10:0] por_cnt_reg, por_cnt_next;
	logic        rx_hunt_reg, rx_hunt_next;
	logic [3:0]  rx_cnt_reg, rx_cnt_next;
	logic [7:0]  rx_sr_reg, rx_sr_next;
	logic        byte_rdy_reg, byte_rdy_next;
	logic [7:0]  ctrl_reg, ctrl_next;
	logic        ext_mode_reg, ext_mode_next;
	logic        pd_req_reg, pd_req_next;
	logic        pd_full_reg, pd_full_next;
	logic        down_reg, down_next;
	logic [15:0] pu_cnt_reg, pu_cnt_next;
	sadc_conv_t  conv_reg, conv_next;
	logic [9:0]  div_cnt_reg, div_cnt_next;
	logic        strobe_reg, strobe_next;
	logic        strobe_oe_reg, strobe_oe_next;
	logic        dout_reg, dout_next;
	logic        dout_oe_reg, dout_oe_next;
	logic        track_reg, track_next;
	logic [OUT_SR_W-1:0] out_sr_reg, out_sr_next;
	logic [4:0]  out_cnt_reg, out_cnt_next;
	logic        ext_pend_reg, ext_pend_next;
	logic        pu_reg, pu_next;
	logic        sar_start, sar_step, sar_bit, sar_done;
	logic [RES_BITS-1:0] sar_result;
	logic        start_ok, go, shut;
	logic [9:0]  div_period;
	logic        sar_step_d_reg, sar_step_d_next;
	logic        busy_reg, busy_next;

	sadc_sync #(.W(SYNC_W)) u_sync (
		.clk   (CLK),
		.rst_n (RST_N),
		.d     ({SCLK, ~CS_N, DIN, ~SHUTDOWN_N_PIN, ~SHUTDOWN_PIN_OPEN}),
		.q     (sync_q)
	);

	// idle-high pins pass inverted so the flush value is their idle level
	assign {sclk_s, cs_n_s, din_s, shutdown_n_pin_n_s, shutdown_n_pin_open_s} = sync_q ^ 5'b01011;
	assign sclk_rise = sclk_s & ~sclk_d_reg & ~cs_n_s;
	assign sclk_fall = ~sclk_s & sclk_d_reg & ~cs_n_s;
	assign cs_rise   = cs_n_s & ~cs_d_reg;
	assign shut      = ~shutdown_n_pin_n_s & ~shutdown_n_pin_open_s;
	// floating pin runs the fast internal clock
	assign div_period = shutdown_n_pin_open_s ? 10'(INT_FAST_CYC) : 10'(INT_SLOW_CYC);

	sadc_sar u_sar (
		.clk    (CLK),
		.rst_n  (RST_N),
		.start  (sar_start),
		.step   (sar_step),
		.sample (ANALOG_CODE),
		.bit_q  (sar_bit),
		.done   (sar_done),
		.result (sar_result)
	);

	// start bit allowed when idle or once three decisions are out
	assign start_ok = (conv_reg == SADC_IDLE) || (out_cnt_reg >= 5'(START_OK_OUT));
	// conversion begins on the fall after the eighth bit
	assign go = sclk_fall && byte_rdy_reg && !shut;

	always_comb begin
		sclk_d_next    = sclk_s;
		cs_d_next      = cs_n_s;
		por_cnt_next   = por_cnt_reg;
		rx_hunt_next   = rx_hunt_reg;
		rx_cnt_next    = rx_cnt_reg;
		rx_sr_next     = rx_sr_reg;
		byte_rdy_next  = byte_rdy_reg;
		ctrl_next      = ctrl_reg;
		ext_mode_next  = ext_mode_reg;
		pd_req_next    = pd_req_reg;
		pd_full_next   = pd_full_reg;
		down_next      = down_reg;
		pu_cnt_next    = pu_cnt_reg;
		conv_next      = conv_reg;
		div_cnt_next   = div_cnt_reg;
		strobe_next    = strobe_reg;
		strobe_oe_next = strobe_oe_reg;
		dout_next      = dout_reg;
		dout_oe_next   = ~cs_n_s && !shut;
		out_sr_next    = out_sr_reg;
		out_cnt_next   = out_cnt_reg;
		ext_pend_next  = ext_pend_reg;
		sar_start      = 1'b0;
		sar_step       = 1'b0;

		// no starts during the power-on reset time
		if (por_cnt_reg != 11'h000)
			por_cnt_next = por_cnt_reg - 11'h001;
		if (pu_cnt_reg != 16'h0000)
			pu_cnt_next = pu_cnt_reg - 16'h0001;

		// receive: sample on rise, first high bit is the start bit
		if (sclk_rise && por_cnt_reg == 11'h000 && !shut) begin
			if (rx_hunt_reg) begin
				if (din_s && start_ok) begin
					rx_hunt_next = 1'b0;
					rx_cnt_next  = 4'h1;
					rx_sr_next   = 8'h01;
					if (down_reg) begin
						// a start bit powers the converter back up
						down_next = 1'b0;
						if (!REF_BUFFER_EN)
							pu_cnt_next = 16'(PU_BUF_OFF_CYC);
						else if (pd_full_reg)
							pu_cnt_next = 16'(PU_FULL_CYCLES);
						else
							pu_cnt_next = 16'(PU_FAST_CYC);
					end
				end
			end else if (!byte_rdy_reg) begin
				rx_sr_next  = {rx_sr_reg[6:0], din_s};
				rx_cnt_next = rx_cnt_reg + 4'h1;
				if (rx_cnt_reg == 4'(CTRL_BITS - 1)) begin
					byte_rdy_next = 1'b1;
					rx_hunt_next  = 1'b1;
					ctrl_next     = {rx_sr_reg[6:0], din_s};
					// power-down bits only change mode when a clock mode is named
					if (rx_sr_reg[0]) begin
						ext_mode_next = din_s;
						pd_req_next   = 1'b0;
					end else begin
						pd_req_next   = 1'b1;
						pd_full_next  = (din_s == PD_FULL[0]);
					end
				end
			end
		end
		// acquire while the final three control bits arrive
		track_next = !rx_hunt_reg && !byte_rdy_reg && rx_cnt_reg >= 4'(TRACK_FROM_BIT);

		// select toggled: receiver hunts again, external conversion stops
		if (cs_rise) begin
			rx_hunt_next  = 1'b1;
			byte_rdy_next = 1'b0;
			if (conv_reg == SADC_EXT) begin
				conv_next   = SADC_IDLE;
				out_sr_next = '0;
			end
		end

		// output shifting on falling edges, MSB first
		if (sclk_fall) begin
			if (conv_reg == SADC_EXT && ext_pend_reg) begin
				ext_pend_next = 1'b0;
				strobe_next   = 1'b0;
				sar_step      = 1'b1;
			end else if (conv_reg == SADC_EXT) begin
				sar_step = 1'b1;
			end else begin
				dout_next   = out_sr_reg[OUT_SR_W-1];
				out_sr_next = {out_sr_reg[OUT_SR_W-2:0], 1'b0};
				if (out_cnt_reg != 5'h1f)
					out_cnt_next = out_cnt_reg + 5'h01;
			end
		end
		// present each external decision as it is made
		if (conv_reg == SADC_EXT && !ext_pend_reg && sar_step_d_reg)
			dout_next = sar_bit;

		// internal clock conversion paced by the divider
		if (conv_reg == SADC_INT) begin
			if (div_cnt_reg == 10'h000) begin
				div_cnt_next = div_period - 10'h001;
				sar_step     = 1'b1;
			end else begin
				div_cnt_next = div_cnt_reg - 10'h001;
			end
			if (sar_done) begin
				conv_next    = SADC_IDLE;
				strobe_next  = 1'b1;
				out_sr_next  = {sar_result, 6'h00};
				out_cnt_next = '0;
			end
		end else if (conv_reg == SADC_EXT && sar_done && !ext_pend_reg && sclk_fall) begin
			conv_next = SADC_IDLE;
		end

		// power down after the conversion ends, in the last clock mode
		if (conv_reg != SADC_IDLE && conv_next == SADC_IDLE && pd_req_reg)
			down_next = 1'b1;
		if (conv_reg == SADC_EXT && sar_step && out_cnt_reg != 5'h1f)
			out_cnt_next = out_cnt_reg + 5'h01;

		// new conversion, aborting any in progress
		if (go) begin
			byte_rdy_next = 1'b0;
			sar_start     = 1'b1;
			out_cnt_next  = '0;
			out_sr_next   = '0;
			if (ext_mode_next) begin
				conv_next     = SADC_EXT;
				ext_pend_next = 1'b0;
				strobe_next   = 1'b1;
				sar_step      = 1'b0;
			end else begin
				conv_next    = SADC_INT;
				strobe_next  = 1'b0;
				div_cnt_next = div_period - 10'h001;
			end
		end
		if (conv_reg == SADC_EXT && strobe_reg && sclk_fall && !go)
			strobe_next = 1'b0;

		// strobe floats in external mode with select high, and whenever the shutdown pin is low
		if (ext_mode_reg) begin
			if (cs_n_s)
				strobe_oe_next = 1'b0;
			else if (!strobe_oe_reg) begin
				strobe_oe_next = 1'b1;
				strobe_next    = 1'b0;
			end
		end else begin
			strobe_oe_next = 1'b1;
		end

		// shutdown pin overrides everything
		if (shut) begin
			conv_next      = SADC_IDLE;
			rx_hunt_next   = 1'b1;
			byte_rdy_next  = 1'b0;
			down_next      = 1'b1;
			pd_full_next   = 1'b1;
			strobe_oe_next = 1'b0;
			dout_oe_next   = 1'b0;
		end
		pu_next = !down_next && pu_cnt_next == 16'h0000;
		sar_step_d_next = sar_step && conv_reg == SADC_EXT;
		busy_next       = (conv_next != SADC_IDLE);
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			sclk_d_reg     <= 1'b0;
			cs_d_reg       <= 1'b1;
			por_cnt_reg    <= 11'(POR_CYC);
			rx_hunt_reg    <= 1'b1;
			rx_cnt_reg     <= 4'h0;
			rx_sr_reg      <= 8'h00;
			byte_rdy_reg   <= 1'b0;
			ctrl_reg       <= 8'h00;
			ext_mode_reg   <= 1'b0;
			pd_req_reg     <= 1'b0;
			pd_full_reg    <= 1'b0;
			down_reg       <= 1'b0;
			pu_cnt_reg     <= 16'h0000;
			conv_reg       <= SADC_IDLE;
			div_cnt_reg    <= 10'h000;
			strobe_reg     <= 1'b1;
			strobe_oe_reg  <= 1'b1;
			dout_reg       <= 1'b0;
			dout_oe_reg    <= 1'b0;
			track_reg      <= 1'b0;
			out_sr_reg     <= '0;
			out_cnt_reg    <= 5'h00;
			ext_pend_reg   <= 1'b0;
			pu_reg         <= 1'b0;
			sar_step_d_reg <= 1'b0;
			busy_reg       <= 1'b0;
		end else begin
			sclk_d_reg     <= sclk_d_next;
			cs_d_reg       <= cs_d_next;
			por_cnt_reg    <= por_cnt_next;
			rx_hunt_reg    <= rx_hunt_next;
			rx_cnt_reg     <= rx_cnt_next;
			rx_sr_reg      <= rx_sr_next;
			byte_rdy_reg   <= byte_rdy_next;
			ctrl_reg       <= ctrl_next;
			ext_mode_reg   <= ext_mode_next;
			pd_req_reg     <= pd_req_next;
			pd_full_reg    <= pd_full_next;
			down_reg       <= down_next;
			pu_cnt_reg     <= pu_cnt_next;
			conv_reg       <= conv_next;
			div_cnt_reg    <= div_cnt_next;
			strobe_reg     <= strobe_next;
			strobe_oe_reg  <= strobe_oe_next;
			dout_reg       <= dout_next;
			dout_oe_reg    <= dout_oe_next;
			track_reg      <= track_next;
			out_sr_reg     <= out_sr_next;
			out_cnt_reg    <= out_cnt_next;
			ext_pend_reg   <= ext_pend_next;
			pu_reg         <= pu_next;
			sar_step_d_reg <= sar_step_d_next;
			busy_reg       <= busy_next;
		end
	end

	assign DOUT                 = dout_reg;
	assign DOUT_OE              = dout_oe_reg;
	assign CONVERSION_STROBE    = strobe_reg;
	assign CONVERSION_STROBE_OE = strobe_oe_reg;
	assign TRACK                = track_reg;
	assign CHANNEL_SELECT       = ctrl_reg[F_SEL_HI:F_SEL_LO];
	assign POLARITY_SELECT      = ctrl_reg[F_POL];
	assign INPUT_CONFIG_SELECT  = ctrl_reg[F_CFG];
	assign EXT_CLOCK_MODE       = ext_mode_reg;
	assign POWERED_UP           = pu_reg;
	assign CONVERTING           = busy_reg;
endmodule

// *** tb/sadc_chk.sv ***
// assertions on the converter control ports
// assumes a serial clock of eight system clocks per period
`timescale 1ns/1ns
module sadc_chk
	import sadc_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CS_N,
	input wire logic SHUTDOWN_N_PIN,
	input wire logic SHUTDOWN_PIN_OPEN,
	input wire logic DOUT,
	input wire logic DOUT_OE,
	input wire logic CONVERSION_STROBE,
	input wire logic CONVERSION_STROBE_OE,
	input wire logic EXT_CLOCK_MODE,
	input wire logic POWERED_UP,
	input wire logic CONVERTING
);
	localparam int MAX_LOW = 937;
	int   low_cnt;
	int   por_cnt;
	logic seen_reg;
	logic int_low;
	logic shutdown_n_pin;
	assign int_low = CONVERSION_STROBE_OE && !CONVERSION_STROBE && !EXT_CLOCK_MODE;
	assign shutdown_n_pin = !SHUTDOWN_N_PIN && !SHUTDOWN_PIN_OPEN;
	default clocking cb @(posedge CLK); endclocking
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			low_cnt <= 0;
			por_cnt <= 0;
			seen_reg <= 1'b0;
		end else begin
			low_cnt <= int_low ? low_cnt + 1 : 0;
			if (por_cnt < POR_CYC) por_cnt <= por_cnt + 1;
			if (CONVERTING) seen_reg <= 1'b1;
		end
	end
	sequence s_strb_on;
		$rose(CONVERSION_STROBE) && CONVERSION_STROBE_OE && EXT_CLOCK_MODE;
	endsequence
	sequence s_one_period;
		CONVERSION_STROBE [*6] ##[1:6] !CONVERSION_STROBE;
	endsequence
	property p_rst_vals;
		!RST_N |=> CONVERSION_STROBE && CONVERSION_STROBE_OE && !DOUT_OE && !EXT_CLOCK_MODE;
	endproperty
	a_strb_pulse: assert property (disable iff (!RST_N) s_strb_on |-> s_one_period)
		else $error("strobe pulse length wrong");
	a_dout_float: assert property (disable iff (!RST_N) CS_N [*5] |-> !DOUT_OE)
		else $error("data out driven with select high");
	a_strb_float: assert property (disable iff (!RST_N) CS_N [*5] ##0 EXT_CLOCK_MODE |-> !CONVERSION_STROBE_OE)
		else $error("strobe driven with select high");
	a_strb_drive: assert property (disable iff (!RST_N) (!EXT_CLOCK_MODE && !shutdown_n_pin) [*5] |-> CONVERSION_STROBE_OE)
		else $error("strobe floats in internal mode");
	a_shutdown_n_pin_stop: assert property (disable iff (!RST_N) shutdown_n_pin [*5] |-> !POWERED_UP && !CONVERTING && !DOUT_OE)
		else $error("active during shutdown");
	a_int_low: assert property (disable iff (!RST_N) SHUTDOWN_PIN_OPEN |-> low_cnt <= MAX_LOW)
		else $error("strobe low too long");
	a_por_quiet: assert property (disable iff (!RST_N) por_cnt < POR_CYC |-> !CONVERTING)
		else $error("conversion during reset time");
	a_zero_out: assert property (disable iff (!RST_N) !seen_reg && !CONVERTING |-> !DOUT)
		else $error("data out not zero before first conversion");
	a_rst_vals: assert property (p_rst_vals)
		else $error("reset state wrong");
endmodule
bind sadc_top sadc_chk i_chk (.CLK(CLK), .RST_N(RST_N), .CS_N(CS_N),
	.SHUTDOWN_N_PIN(SHUTDOWN_N_PIN), .SHUTDOWN_PIN_OPEN(SHUTDOWN_PIN_OPEN),
	.DOUT(DOUT), .DOUT_OE(DOUT_OE), .CONVERSION_STROBE(CONVERSION_STROBE),
	.CONVERSION_STROBE_OE(CONVERSION_STROBE_OE), .EXT_CLOCK_MODE(EXT_CLOCK_MODE),
	.POWERED_UP(POWERED_UP), .CONVERTING(CONVERTING));

// *** tb/sadc_host.sv ***
// host serial master model, clock idle low, data set before rise
// assumes half a serial period of four system clocks
`timescale 1ns/1ns
module sadc_host (
	input  wire logic        clk,
	input  wire logic        dout,
	input  wire logic        dout_oe,
	output logic             cs_n,
	output logic             sclk,
	output logic             din,
	output logic [63:0]      q
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din = 1'b0;
		q = '0;
	end
	task automatic half();
		repeat (4) @(posedge clk);
		#1;
	endtask
	// bit i goes out on rise i, q[i] is taken just before fall i
	task automatic xfer(input int n, input logic [63:0] b);
		cs_n = 1'b0;
		half();
		for (int i = 0; i < n; i++) begin
			din = b[i];
			half();
			sclk = 1'b1;
			half();
			q[i] = dout_oe ? dout : ~dout;
			sclk = 1'b0;
		end
		half();
		cs_n = 1'b1;
		din = 1'b0;
		half();
	endtask
endmodule

// *** tb/tb.sv ***
// self-checking bench for the converter control block
// assumes the host model drives the serial pins
`timescale 1ns/1ns
module tb;
	import sadc_pkg::*;
	logic                clk = 1'b0;
	logic                rst_n = 1'b0;
	logic                shutdown_n_pin_n = 1'b1;
	logic                shutdown_n_pin_open = 1'b1;
	logic                ref_en = 1'b0;
	logic [RES_BITS-1:0] code = '0;
	logic [2:0]          chan, ch_o;
	logic                pol, cfg, pol_o, cfg_o;
	logic                cs_n, sclk, din, dout, dout_oe, strb, strb_oe, ext, pwr, conv;
	logic [63:0]         q;
	logic [31:0]         seed = 32'h4fa0;
	logic [7:0]          c;
	int                  fail_count = 0;
	int                  n_tests = 0;
	int                  cyc = 0;
	int                  t, n;
	logic                trk;
	int                  trk_n = 0;
	always #4 clk = ~clk;
	sadc_top #(.PU_FULL_CYCLES(100)) i_dut (.CLK(clk), .RST_N(rst_n), .CS_N(cs_n),
		.SCLK(sclk), .DIN(din), .SHUTDOWN_N_PIN(shutdown_n_pin_n), .SHUTDOWN_PIN_OPEN(shutdown_n_pin_open),
		.REF_BUFFER_EN(ref_en), .ANALOG_CODE(code), .DOUT(dout), .DOUT_OE(dout_oe),
		.CONVERSION_STROBE(strb), .CONVERSION_STROBE_OE(strb_oe), .TRACK(trk),
		.CHANNEL_SELECT(ch_o), .POLARITY_SELECT(pol_o), .INPUT_CONFIG_SELECT(cfg_o),
		.EXT_CLOCK_MODE(ext), .POWERED_UP(pwr), .CONVERTING(conv));
	sadc_host i_host (.clk(clk), .dout(dout), .dout_oe(dout_oe), .cs_n(cs_n), .sclk(sclk),
		.din(din), .q(q));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [63:0] put(input logic [63:0] b, input int o, input logic [7:0] v);
		for (int i = 0; i < 8; i++) b[o + i] = v[7 - i];
		return b;
	endfunction
	task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic chk_rng(input string s, input int lo, input int hi, input int g);
		n_tests++;
		if (g < lo || g > hi) begin
			fail_count++;
			$display("ERROR %s expected %0d..%0d seen %0d", s, lo, hi, g);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic tend(input string s);
		$display("end of %s", s);
	endtask
	task automatic wait_clk(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic rnd_ctrl(input logic [1:0] pd, output logic [7:0] v);
		logic [31:0] r;
		r = rnd();
		chan = r[2:0];
		pol = r[3];
		cfg = r[4];
		code = r[14:5];
		v = {1'b1, chan, pol, cfg, pd};
	endtask
	// model: ten result bits, two zero sub-bits, msb first
	task automatic chk_res(input int o);
		int exp_q[$];
		for (int k = RES_BITS - 1; k >= 0; k--) exp_q.push_back(int'(code[k]));
		repeat (2) exp_q.push_back(0);
		for (int k = 0; k < 12; k++)
			chk("dout", 16'(exp_q.pop_front()), 16'(q[o + k]));
	endtask
	task automatic frame(input logic [1:0] pd, input int o);
		logic [7:0] v;
		rnd_ctrl(pd, v);
		trk_n = 0;
		i_host.xfer(o + 24, put(64'h0, o, v));
		chk("track", 16'(3 * 8), 16'(trk_n));
		chk("fields", 16'({chan, pol, cfg}), 16'({ch_o, pol_o, cfg_o}));
		if (pd[1]) chk("ext", 16'(pd[0]), 16'(ext));
		chk_res(o + 9);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (trk === 1'b1) trk_n++;
		if (cyc == 30000) begin
			fail_count++;
			finish_test();
		end
	end
	initial begin
		wait_clk(6);
		rst_n = 1'b1;
		i_host.xfer(16, 64'h0);
		chk("dout", 16'h0, q[15:0]);
		i_host.xfer(8, put(64'h0, 0, 8'hff));
		chk("conv", 16'h0, 16'(conv));
		wait_clk(POR_CYC);
		tend("power on");
		for (int i = 0; i < 4; i++) frame(2'b11, i);
		tend("external");
		for (int g = 15; g <= 16; g++) begin
			rnd_ctrl(2'b11, c);
			i_host.xfer(g + 24, put(put(64'h0, 0, c), g, c));
			chk_res(9);
			chk_res(g + 9);
		end
		tend("back to back");
		rnd_ctrl(2'b11, c);
		i_host.xfer(12, put(64'h0, 0, c));
		wait_clk(4);
		chk("conv", 16'h0, 16'(conv));
		frame(2'b11, 0);
		tend("abort");
		for (int k = 0; k < 2; k++) begin
			shutdown_n_pin_open = (k == 0);
			rnd_ctrl(2'b10, c);
			i_host.xfer(8, put(64'h0, 0, c));
			chk("ext", 16'h0, 16'(ext));
			t = k ? INT_SLOW_CYC : INT_FAST_CYC;
			n = 0;
			while (strb !== 1'b1 && n < 8000) begin
				wait_clk(1);
				n++;
			end
			chk_rng("low time", 11 * t, 13 * t, n);
			i_host.xfer(16, 64'h0);
			chk_res(1);
		end
		tend("internal");
		shutdown_n_pin_open = 1'b0;
		ref_en = 1'b1;
		frame(2'b11, 0);
		for (int k = 0; k < 2; k++) begin
			frame(2'(k), 0);
			wait_clk(20);
			chk("pwr", 16'h0, 16'(pwr));
			frame(2'b11, 0);
			wait_clk((k ? PU_FAST_CYC : 100) + 40);
			chk("pwr", 16'h1, 16'(pwr));
		end
		shutdown_n_pin_n = 1'b0;
		i_host.xfer(8, put(64'h0, 0, c));
		chk("conv", 16'h0, 16'(conv));
		chk("pwr", 16'h0, 16'(pwr));
		shutdown_n_pin_n = 1'b1;
		shutdown_n_pin_open = 1'b1;
		frame(2'b11, 0);
		tend("power down");
		finish_test();
	end
endmodule
